// file: hdl/c8d_pkg.sv
// constants and types of the 8-bit register/alu datapath
package c8d_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_T1 = 3'b001, ST_T2 = 3'b011,
    ST_T3   = 3'b010, ST_T4 = 3'b110, ST_TW = 3'b111
  } c8d_state_t;
  typedef enum logic [1:0] {
    CK_FETCH = 2'b00, CK_READ = 2'b01, CK_WRITE = 2'b10, CK_INT = 2'b11
  } c8d_kind_t;
  typedef enum logic [2:0] {
    BS_NONE = 3'h0, BS_PINS = 3'h1, BS_REG = 3'h2, BS_ACC = 3'h3,
    BS_TMP  = 3'h4, BS_ALU  = 3'h5, BS_IR  = 3'h6, BS_FLAG = 3'h7
  } c8d_bsrc_t;
  typedef enum logic [3:0] {
    AF_ADD = 4'h0, AF_ADC = 4'h1, AF_SUB = 4'h2, AF_SBB = 4'h3,
    AF_AND = 4'h4, AF_XOR = 4'h5, AF_OR  = 4'h6, AF_CMP = 4'h7,
    AF_RLC = 4'h8, AF_RRC = 4'h9, AF_RAL = 4'ha, AF_RAR = 4'hb,
    AF_DEC = 4'hc, AF_PASS = 4'hd
  } c8d_afn_t;
  typedef enum logic [1:0] {
    ID_PASS = 2'b00, ID_INC = 2'b01, ID_DEC = 2'b10
  } c8d_idu_t;
  // pair indices, pair count and last byte select code of the register array
  localparam logic [2:0]  PR_SCR   = 3'd3;
  localparam logic [2:0]  PR_PC    = 3'd4;
  localparam logic [2:0]  PR_SP    = 3'd5;
  localparam int          NPAIR    = 6;
  localparam logic [2:0]  SEL_LAST = 3'd5;
  // flag bit positions
  localparam int          FB_CY = 0;
  localparam int          FB_P  = 1;
  localparam int          FB_AC = 2;
  localparam int          FB_Z  = 3;
  localparam int          FB_S  = 4;
  // reset and idle values, decimal adjust constants and opcode
  localparam logic [15:0] PAIR_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [4:0]  FLAG_RST = 5'h00;
  localparam logic [7:0]  PRE_VAL  = 8'hff;
  localparam logic [3:0]  BCD_MAX  = 4'h9;
  localparam logic [7:0]  BCD_LO   = 8'h06;
  localparam logic [7:0]  BCD_HI   = 8'h60;
  localparam logic [7:0]  OP_DAA   = 8'h27;
endpackage

// file: hdl/c8d_datapath.sv
// register array, address logic, alu, instruction register and data buffer
// Function
// - 8-bit two-way data bus with tri-state drive, separate from address bus.
// - six timing/control outputs, four control inputs, two clock phase inputs.
// - register array holds six 16-bit pairs including pc, sp, scratch.
// - program counter increments automatically on every instruction fetch.
// - stack pointer decrements on push, increments on pop.
// - general registers usable as single bytes or as 16-bit pairs.
// - scratch pair cannot be selected by program byte select codes.
// - byte moves via select mux; word moves via address latch/incrementer.
// - address latch loads from any pair, drives address pins and incrementer.
// - incrementer returns latch value incremented, decremented or unchanged.
// - alu holds accumulator, shadow accumulator, operand temp, 5-bit flags.
// - alu operates on temp, shadow and carry; result to bus or accumulator.
// - operand temp loads from bus, feeds alu, flags and bus.
// - accumulator loads from alu or bus, copies to shadow and bus.
// - decimal adjust tests accumulator and auxiliary carry for correction.
// - fetch moves opcode byte from internal bus to instruction register.
// - decoder plus timing make controls; cycle requests and inputs drive state timing.
// - output mode latches bus into pin latch; drivers off otherwise.
// - input mode passes external data onto internal bus.
// - internal bus precharged each state except wait and third transfer state.
// - cycle-start strobe launched on rising second phase at cycle start, except on interrupt cycles.
`timescale 1ns/1ps
module c8d_datapath
  import c8d_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // phase and control pins
  input  wire logic             phase1,
  input  wire logic             phase2,
  input  wire logic             ready,
  input  wire logic             hold_req,
  input  wire logic             int_req,
  input  wire logic             sys_reset,
  // timing and control outputs
  output logic                  sync,
  output logic                  data_in_strobe,
  output logic                  wait_out,
  output logic                  write_n,
  output logic                  hold_grant,
  output logic                  interrupt_enable_out,
  // system buses
  input  wire logic [7:0]       data_i,
  output logic [7:0]            data_o,
  output logic                  data_oe,
  output logic [15:0]           addr_o,
  // cycle requests from the sequencer
  input  wire logic             cyc_req,
  input  wire c8d_pkg::c8d_kind_t cyc_kind,
  input  wire logic [2:0]       cyc_pair,
  input  wire logic             cyc_alu,
  input  wire logic             alu_use_ir,
  input  wire c8d_pkg::c8d_afn_t alu_fn,
  // transfer controls
  input  wire c8d_pkg::c8d_bsrc_t bus_src,
  input  wire logic [2:0]       rd_sel,
  input  wire logic             rd_scr,
  input  wire logic             bw_en,
  input  wire logic [2:0]       bw_sel,
  input  wire logic             bw_scr,
  input  wire logic             wb_en,
  input  wire logic [2:0]       wb_dst,
  input  wire c8d_pkg::c8d_idu_t idu_mode,
  input  wire logic             sp_push,
  input  wire logic             sp_pop,
  input  wire logic             acc_ld,
  input  wire logic             acc_to_act,
  input  wire logic             tmp_ld,
  input  wire logic             flag_from_tmp,
  input  wire logic             ie_set,
  input  wire logic             ie_clr,
  // status
  output logic                  busy,
  output logic                  precharge,
  output logic                  int_pending,
  output logic [7:0]            ir_out,
  output logic [7:0]            acc_out,
  output logic [4:0]            flags_out
);
  import c8d_pkg::*;

  // pin synchronisers
  logic [5:0] pin_m_reg, pin_s_reg;
  logic [7:0] din_m_reg, din_s_reg;
  logic       ph1_d_reg, ph2_d_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_reg <= 6'h00;
      pin_s_reg <= 6'h00;
      din_m_reg <= BYTE_RST;
      din_s_reg <= BYTE_RST;
      ph1_d_reg <= 1'b0;
      ph2_d_reg <= 1'b0;
    end else begin
      pin_m_reg <= {sys_reset, int_req, hold_req, ready, phase2, phase1};
      pin_s_reg <= pin_m_reg;
      din_m_reg <= data_i;
      din_s_reg <= din_m_reg;
      ph1_d_reg <= pin_s_reg[0];
      ph2_d_reg <= pin_s_reg[1];
    end
  end
  logic st_en, ph2_rise, rdy_s, hold_s, int_s, srst_s;
  assign st_en    = pin_s_reg[0] & ~ph1_d_reg;
  assign ph2_rise = pin_s_reg[1] & ~ph2_d_reg;
  assign rdy_s    = pin_s_reg[2];
  assign hold_s   = pin_s_reg[3];
  assign int_s    = pin_s_reg[4];
  assign srst_s   = pin_s_reg[5];

  // state timing
  c8d_state_t state_reg, state_next;
  c8d_kind_t  kind_reg;
  logic [2:0] apair_reg;
  logic       alu_req_reg, alu_ir_reg, hold_grant_reg;
  c8d_afn_t   afn_reg;
  logic       start_ok;
  assign start_ok = cyc_req & ~hold_s;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (start_ok) state_next = ST_T1;
      ST_T1:   state_next = ST_T2;
      ST_T2:   state_next = (rdy_s || kind_reg == CK_INT) ? ST_T3 : ST_TW;
      ST_TW:   if (rdy_s) state_next = ST_T3;
      ST_T3:   state_next = (kind_reg == CK_FETCH || alu_req_reg) ? ST_T4
                          : (start_ok ? ST_T1 : ST_IDLE);
      ST_T4:   state_next = start_ok ? ST_T1 : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end
  logic cyc_take;
  assign cyc_take = st_en && state_next == ST_T1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (srst_s) begin
      state_reg <= ST_IDLE;
    end else if (st_en) begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_reg    <= CK_FETCH;
      apair_reg   <= PR_PC;
      alu_req_reg <= 1'b0;
      alu_ir_reg  <= 1'b0;
      afn_reg     <= AF_ADD;
    end else if (cyc_take) begin
      kind_reg    <= cyc_kind;
      apair_reg   <= cyc_pair;
      alu_req_reg <= cyc_alu;
      alu_ir_reg  <= alu_use_ir;
      afn_reg     <= alu_fn;
    end
  end

  // control outputs
  logic sync_reg, pchg_reg, ie_reg;
  logic is_rd, is_wr, xfer_st;
  assign is_rd   = kind_reg == CK_FETCH || kind_reg == CK_READ;
  assign is_wr   = kind_reg == CK_WRITE;
  assign xfer_st = state_reg inside {ST_T2, ST_TW, ST_T3};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg       <= 1'b0;
      pchg_reg       <= 1'b0;
      hold_grant_reg <= 1'b0;
    end else begin
      sync_reg       <= ph2_rise && state_reg == ST_T1 && kind_reg != CK_INT;
      pchg_reg       <= st_en && !(state_next inside {ST_TW, ST_T3});
      hold_grant_reg <= hold_s && state_reg == ST_IDLE;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_reg <= 1'b0;
    end else if (srst_s || ie_clr) begin
      ie_reg <= 1'b0;
    end else if (ie_set) begin
      ie_reg <= 1'b1;
    end
  end
  assign sync                 = sync_reg;
  assign precharge            = pchg_reg;
  assign hold_grant           = hold_grant_reg;
  assign interrupt_enable_out = ie_reg;
  assign int_pending          = int_s & ie_reg;
  assign data_in_strobe       = is_rd && xfer_st;
  assign wait_out             = state_reg == ST_TW;
  assign write_n              = !(is_wr && xfer_st);
  assign data_oe              = is_wr && xfer_st;
  assign busy                 = state_reg != ST_IDLE;

  // register array and internal bus
  logic [15:0] rf_reg [NPAIR];
  logic [15:0] alat_reg, idu_out, idu_inc;
  logic [7:0]  ibus, rd_byte, alu_res, acc_reg, act_reg, tmp_reg, ir_reg, dout_reg;
  logic [4:0]  flag_reg, alu_flg;
  logic [2:0]  rd_pair, bw_pair;
  logic        bw_ok, pc_inc;
  assign rd_pair = rd_scr ? PR_SCR : {1'b0, rd_sel[2:1]};
  assign bw_pair = bw_scr ? PR_SCR : {1'b0, bw_sel[2:1]};
  assign bw_ok   = bw_en && (bw_scr || bw_sel <= SEL_LAST);
  assign rd_byte = (!rd_scr && rd_sel > SEL_LAST) ? BYTE_RST :
                   rd_sel[0] ? rf_reg[rd_pair][7:0] : rf_reg[rd_pair][15:8];
  always_comb begin
    if (state_reg == ST_T3 && is_rd) begin
      ibus = din_s_reg;
    end else begin
      unique case (bus_src)
        BS_PINS: ibus = din_s_reg;
        BS_REG:  ibus = rd_byte;
        BS_ACC:  ibus = acc_reg;
        BS_TMP:  ibus = tmp_reg;
        BS_ALU:  ibus = alu_res;
        BS_IR:   ibus = ir_reg;
        BS_FLAG: ibus = {3'b000, flag_reg};
        BS_NONE: ibus = PRE_VAL;
      endcase
    end
  end

  // address latch and incrementer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alat_reg <= PAIR_RST;
    end else if (cyc_take) begin
      alat_reg <= rf_reg[cyc_pair];
    end
  end
  assign addr_o  = alat_reg;
  assign idu_inc = alat_reg + 16'h0001;
  assign idu_out = idu_mode == ID_INC ? idu_inc :
                   idu_mode == ID_DEC ? alat_reg - 16'h0001 : alat_reg;
  assign pc_inc  = st_en && state_reg == ST_T1 && kind_reg == CK_FETCH;

  generate
    for (genvar j = 0; j < NPAIR; j++) begin : g_pair
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rf_reg[j] <= PAIR_RST;
        end else if (srst_s) begin
          rf_reg[j] <= PAIR_RST;
        end else if (j == PR_PC && pc_inc) begin
          rf_reg[j] <= idu_inc;
        end else if (wb_en && wb_dst == 3'(j)) begin
          rf_reg[j] <= idu_out;
        end else if (j == PR_SP && sp_push) begin
          rf_reg[j] <= rf_reg[j] - 16'h0001;
        end else if (j == PR_SP && sp_pop) begin
          rf_reg[j] <= rf_reg[j] + 16'h0001;
        end else if (bw_ok && bw_pair == 3'(j)) begin
          if (bw_sel[0]) rf_reg[j][7:0] <= ibus;
          else rf_reg[j][15:8] <= ibus;
        end
      end
    end
  endgenerate

  // instruction register and decoder
  c8d_afn_t dec_fn, fn;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_reg <= BYTE_RST;
    end else if (st_en && state_reg == ST_T3 && kind_reg == CK_FETCH) begin
      ir_reg <= ibus;
    end
  end
  always_comb begin
    if (ir_reg == OP_DAA) dec_fn = AF_DEC;
    else if (ir_reg[7:6] == 2'b10) dec_fn = c8d_afn_t'({1'b0, ir_reg[5:3]});
    else if (ir_reg[7:5] == 3'b000 && ir_reg[2:0] == 3'b111)
      dec_fn = c8d_afn_t'({2'b10, ir_reg[4:3]});
    else dec_fn = AF_PASS;
  end
  assign fn = alu_ir_reg ? dec_fn : afn_reg;

  // alu
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic [7:0] bx;
  logic       cin, sub, res_c, res_ac;
  always_comb begin
    sub    = fn inside {AF_SUB, AF_SBB, AF_CMP};
    bx     = sub ? ~tmp_reg : tmp_reg;
    cin    = sub ^ (fn inside {AF_ADC, AF_SBB} && flag_reg[FB_CY]);
    sum9   = {1'b0, act_reg} + {1'b0, bx} + {8'h00, cin};
    lo5    = {1'b0, act_reg[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    alu_res = sum9[7:0];
    res_c  = sum9[8] ^ sub;
    res_ac = lo5[4];
    unique case (fn)
      AF_AND: begin alu_res = act_reg & tmp_reg; res_c = 1'b0; end
      AF_XOR: begin alu_res = act_reg ^ tmp_reg; res_c = 1'b0; res_ac = 1'b0; end
      AF_OR:  begin alu_res = act_reg | tmp_reg; res_c = 1'b0; res_ac = 1'b0; end
      AF_RLC: begin alu_res = {act_reg[6:0], act_reg[7]}; res_c = act_reg[7]; end
      AF_RRC: begin alu_res = {act_reg[0], act_reg[7:1]}; res_c = act_reg[0]; end
      AF_RAL: begin alu_res = {act_reg[6:0], flag_reg[FB_CY]}; res_c = act_reg[7]; end
      AF_RAR: begin alu_res = {flag_reg[FB_CY], act_reg[7:1]}; res_c = act_reg[0]; end
      AF_DEC: begin
        bx = (acc_reg[3:0] > BCD_MAX || flag_reg[FB_AC]) ? BCD_LO : BYTE_RST;
        lo5 = {1'b0, acc_reg[3:0]} + {1'b0, bx[3:0]};
        sum9 = {1'b0, acc_reg} + {1'b0, bx};
        res_ac = lo5[4];
        res_c = flag_reg[FB_CY] || sum9[8] || sum9[7:4] > BCD_MAX;
        alu_res = sum9[7:0] + (res_c ? BCD_HI : BYTE_RST);
      end
      AF_PASS: begin alu_res = tmp_reg; res_c = flag_reg[FB_CY]; end
      default: ;
    endcase
    alu_flg = {alu_res[7], alu_res == BYTE_RST, res_ac, ~^alu_res, res_c};
  end

  // accumulator, shadow, operand temp and flags
  logic alu_go;
  assign alu_go = st_en && state_reg == ST_T4 && alu_req_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= BYTE_RST;
    end else if (alu_go && fn != AF_CMP) begin
      acc_reg <= alu_res;
    end else if (acc_ld) begin
      acc_reg <= ibus;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= BYTE_RST;
    end else if (acc_to_act) begin
      act_reg <= acc_reg;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmp_reg <= BYTE_RST;
    end else if (st_en && state_reg == ST_T3 && kind_reg == CK_READ) begin
      tmp_reg <= ibus;
    end else if (tmp_ld) begin
      tmp_reg <= ibus;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= FLAG_RST;
    end else if (alu_go) begin
      flag_reg <= alu_flg;
    end else if (flag_from_tmp) begin
      flag_reg <= {tmp_reg[7], tmp_reg[6], tmp_reg[4], tmp_reg[2], tmp_reg[0]};
    end
  end
  assign ir_out    = ir_reg;
  assign acc_out   = acc_reg;
  assign flags_out = flag_reg;

  // data buffer output latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_reg <= BYTE_RST;
    end else if (st_en && state_reg == ST_T1 && kind_reg == CK_WRITE) begin
      dout_reg <= ibus;
    end
  end
  assign data_o = dout_reg;

  // checks
  sequence s_wait_done;
    state_reg == ST_TW && st_en && rdy_s;
  endsequence
  a_sync_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    sync |-> $past(state_reg) == ST_T1 && $past(ph2_rise)) else $error("sync outside T1");
  a_pchg_skip: assert property (@(posedge clk) disable iff (!rst_n)
    precharge |-> !(state_reg inside {ST_TW, ST_T3})) else $error("precharge in TW/T3");
  a_oe_write: assert property (@(posedge clk) disable iff (!rst_n)
    data_oe && $past(data_oe) |-> is_wr && !write_n && $stable(data_o))
    else $error("pin latch moved while driving");
  a_pc_fetch: assert property (@(posedge clk) disable iff (!rst_n || srst_s)
    pc_inc |=> rf_reg[PR_PC] == $past(alat_reg) + 16'h0001) else $error("pc not bumped");
  a_wait_exit: assert property (@(posedge clk) disable iff (!rst_n || srst_s)
    s_wait_done |=> state_reg == ST_T3 && !wait_out) else $error("wait not left");
  a_ir_load: assert property (@(posedge clk) disable iff (!rst_n)
    st_en && state_reg == ST_T3 && kind_reg == CK_FETCH |=> ir_reg == $past(din_s_reg))
    else $error("opcode not captured");
  a_sp_push: assert property (@(posedge clk) disable iff (!rst_n || srst_s)
    sp_push && !(wb_en && wb_dst == PR_SP) |=> rf_reg[PR_SP] == $past(rf_reg[PR_SP]) - 16'h0001)
    else $error("push did not decrement");
  a_scr_guard: assert property (@(posedge clk) disable iff (!rst_n || srst_s)
    !bw_scr && !(wb_en && wb_dst == PR_SCR) |=> $stable(rf_reg[PR_SCR]))
    else $error("scratch written by program select");
  a_addr_latch: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_take |=> addr_o == $past(rf_reg[cyc_pair])) else $error("latch not loaded");
endmodule

// file: testbench/c8d_mem_model.sv
// memory and peripheral model on the system bus of the datapath
`timescale 1ns/1ps
module c8d_mem_model (
  input  wire logic        clk,
  input  wire logic        data_in_strobe,
  input  wire logic [15:0] addr_o,
  input  wire logic [7:0]  data_o,
  input  wire logic        data_oe,
  output logic [7:0]       data_i
);
  logic [7:0] mem [0:255];
  logic [7:0] last_reg = 8'h00;
  // released bus shows the inverse of the last value
  always_comb data_i = data_in_strobe ? mem[addr_o[7:0]] : ~last_reg;
  always @(posedge clk) begin
    if (data_in_strobe) last_reg <= mem[addr_o[7:0]];
    if (data_oe) mem[addr_o[7:0]] <= data_o;
  end
endmodule

// file: testbench/c8d_datapath_tb.sv
// self-checking bench of the register/alu datapath
`timescale 1ns/1ps
module c8d_datapath_tb;
  import c8d_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, phase1 = 1'b0, phase2 = 1'b0, ready = 1'b1;
  logic hold_req = 1'b0, int_req = 1'b0, sys_reset = 1'b0, cyc_req = 1'b0;
  logic cyc_alu = 1'b0, bw_en = 1'b0, bw_scr = 1'b0, wb_en = 1'b0;
  logic sp_push = 1'b0, sp_pop = 1'b0, acc_ld = 1'b0, acc_to_act = 1'b0;
  logic ie_set = 1'b0, ie_clr = 1'b0;
  logic rd_scr = 1'b0, alu_use_ir = 1'b0, tmp_ld = 1'b0, flag_from_tmp = 1'b0;
  logic [2:0] cyc_pair = 3'h0, rd_sel = 3'h0, bw_sel = 3'h0, wb_dst = 3'h0;
  c8d_kind_t  cyc_kind = CK_FETCH;
  c8d_afn_t   alu_fn = AF_PASS;
  c8d_bsrc_t  bus_src = BS_NONE;
  c8d_idu_t   idu_mode = ID_PASS;
  logic sync, data_in_strobe, wait_out, write_n, hold_grant, interrupt_enable_out;
  logic data_oe, busy, precharge, int_pending;
  logic [7:0]  data_i, data_o, ir_out, acc_out;
  logic [4:0]  flags_out;
  logic [15:0] addr_o;
  int          failures = 0, cmp_count = 0, ph = 0;
  logic [15:0] pr [0:5];
  logic [7:0]  acc_e, t;

  c8d_datapath dut (.clk, .rst_n, .phase1, .phase2, .ready, .hold_req, .int_req,
    .sys_reset, .sync, .data_in_strobe, .wait_out, .write_n, .hold_grant,
    .interrupt_enable_out, .data_i, .data_o, .data_oe, .addr_o, .cyc_req, .cyc_kind,
    .cyc_pair, .cyc_alu, .alu_use_ir, .alu_fn, .bus_src, .rd_sel, .rd_scr, .bw_en,
    .bw_sel, .bw_scr, .wb_en, .wb_dst, .idu_mode, .sp_push, .sp_pop, .acc_ld,
    .acc_to_act, .tmp_ld, .flag_from_tmp, .ie_set, .ie_clr, .busy, .precharge,
    .int_pending, .ir_out, .acc_out, .flags_out);
  c8d_mem_model mem (.clk, .data_in_strobe, .addr_o, .data_o, .data_oe, .data_i);

  always #2 clk = ~clk;
  // two non-overlapping phases, eight clocks a state
  always @(posedge clk) begin
    #1;
    ph = (ph + 1) % 8;
    phase1 = (ph < 2);
    phase2 = (ph >= 3 && ph <= 5);
    ready = ($urandom % 3) != 0;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  function automatic logic [7:0] alu_exp(input c8d_afn_t f, input logic [7:0] a, b);
    case (f)
      AF_ADD:  return a + b;
      AF_SUB:  return a - b;
      AF_AND:  return a & b;
      AF_XOR:  return a ^ b;
      default: return a | b;
    endcase
  endfunction

  // decimal correction: {carry, result}
  function automatic logic [8:0] daa_exp(input logic [7:0] a, input logic ac, input logic cy);
    int v;
    logic c;
    v = a;
    if (a[3:0] > 4'h9 || ac) v += 8'h06;
    c = cy || v >= 8'ha0;
    if (c) v += 8'h60;
    return {c, v[7:0]};
  endfunction

  // one machine cycle, watched clock by clock
  task automatic run(input c8d_kind_t k, input logic [2:0] p, input logic alu,
                     input c8d_afn_t fn);
    int n, syncs, strobes;
    logic [15:0] a;
    n = 0;
    syncs = 0;
    strobes = 0;
    a = 16'h0;
    cyc_kind = k;
    cyc_pair = p;
    cyc_alu = alu;
    alu_fn = fn;
    cyc_req = 1'b1;
    while (busy !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    cyc_req = 1'b0;
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk);
      syncs += sync;
      strobes += data_in_strobe;
      if (data_in_strobe || !write_n) a = addr_o;
      check(data_oe, !write_n, "drive enable");
      if (wait_out) check(precharge, 1'b0, "precharge in wait");
      tick(1);
      n++;
    end
    if (n >= 400) failures++;
    check(syncs, 1, "sync count");
    check(a, pr[p], "address");
    check(strobes > 0, k != CK_WRITE, "read strobe");
    if (k == CK_FETCH) pr[PR_PC] = pr[p] + 16'h1;
  endtask

  task automatic results();
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin : main
    c8d_idu_t m;
    c8d_afn_t fl [5];
    logic [8:0] d;
    fl = '{AF_AND, AF_XOR, AF_OR, AF_ADD, AF_SUB};
    void'($urandom(32'h0422));
    foreach (pr[i]) pr[i] = PAIR_RST;
    for (int i = 0; i < 256; i++) mem.mem[i] = 8'($urandom);
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    check(write_n, 1'b1, "reset write");
    check(data_oe, 1'b0, "reset drive");
    check(acc_out, BYTE_RST, "reset acc");
    check(flags_out, FLAG_RST, "reset flags");
    tick(4);
    $display("test reset done");
    run(CK_FETCH, PR_PC, 1'b0, AF_PASS);
    run(CK_FETCH, PR_PC, 1'b0, AF_PASS);
    check(ir_out, mem.mem[1], "opcode");
    $display("test fetch done");
    run(CK_READ, 3'd0, 1'b0, AF_PASS);
    acc_e = mem.mem[0];
    bus_src = BS_TMP;
    pulse(acc_ld);
    check(acc_out, acc_e, "acc from tmp");
    bus_src = BS_ACC;
    mem.mem[0] = ~acc_e;
    run(CK_WRITE, 3'd0, 1'b0, AF_PASS);
    check(mem.mem[0], acc_e, "written byte");
    $display("test read write done");
    bw_sel = 3'd1;
    pulse(bw_en);
    pr[0][7:0] = acc_e;
    bw_sel = 3'd6;
    pulse(bw_en);
    bw_sel = 3'd7;
    bw_scr = 1'b1;
    pulse(bw_en);
    bw_scr = 1'b0;
    pr[3][7:0] = acc_e;
    run(CK_READ, 3'd0, 1'b0, AF_PASS);
    run(CK_READ, PR_SCR, 1'b0, AF_PASS);
    $display("test byte select done");
    m = m.first;
    repeat (3) begin
      run(CK_READ, 3'd0, 1'b0, AF_PASS);
      wb_dst = 3'd1;
      idu_mode = m;
      pulse(wb_en);
      pr[1] = pr[0] + (m == ID_INC) - (m == ID_DEC);
      run(CK_READ, 3'd1, 1'b0, AF_PASS);
      m = m.next;
    end
    pulse(sp_push);
    pr[PR_SP] = pr[PR_SP] - 16'h1;
    run(CK_READ, PR_SP, 1'b0, AF_PASS);
    pulse(sp_pop);
    pulse(sp_pop);
    pr[PR_SP] = pr[PR_SP] + 16'h2;
    run(CK_READ, PR_SP, 1'b0, AF_PASS);
    $display("test pairs done");
    foreach (fl[i]) begin
      pulse(acc_to_act);
      run(CK_READ, 3'd1, 1'b0, AF_PASS);
      t = mem.mem[pr[1][7:0]];
      run(CK_FETCH, PR_PC, 1'b1, fl[i]);
      acc_e = alu_exp(fl[i], acc_e, t);
      check(acc_out, acc_e, "alu result");
      check(flags_out[FB_Z], acc_e == 8'h00, "zero flag");
      check(flags_out[FB_S], acc_e[7], "sign flag");
      check(flags_out[FB_P], ~^acc_e, "parity flag");
    end
    run(CK_READ, 3'd1, 1'b0, AF_PASS);
    pulse(flag_from_tmp);
    check(flags_out, {t[7], t[6], t[4], t[2], t[0]}, "flags from temp");
    d = daa_exp(acc_e, t[4], t[0]);
    mem.mem[pr[PR_PC][7:0]] = OP_DAA;
    alu_use_ir = 1'b1;
    run(CK_FETCH, PR_PC, 1'b1, AF_PASS);
    alu_use_ir = 1'b0;
    check(ir_out, OP_DAA, "decimal opcode");
    check({flags_out[FB_CY], acc_out}, d, "decimal adjust");
    acc_e = d[7:0];
    $display("test alu done");
    hold_req = 1'b1;
    tick(8);
    check(hold_grant, 1'b1, "hold grant");
    cyc_req = 1'b1;
    tick(40);
    check(busy, 1'b0, "cycle under hold");
    cyc_req = 1'b0;
    hold_req = 1'b0;
    tick(8);
    check(hold_grant, 1'b0, "hold release");
    int_req = 1'b1;
    pulse(ie_set);
    check(interrupt_enable_out, 1'b1, "ie set");
    check(int_pending, 1'b1, "int pending");
    ie_set = 1'b1;
    ie_clr = 1'b1;
    tick(1);
    ie_set = 1'b0;
    ie_clr = 1'b0;
    tick(1);
    check(interrupt_enable_out, 1'b0, "ie clear wins");
    pulse(ie_set);
    pulse(sys_reset);
    tick(2);
    check(interrupt_enable_out, 1'b0, "ie after pin reset");
    foreach (pr[i]) pr[i] = PAIR_RST;
    run(CK_READ, 3'd1, 1'b0, AF_PASS);
    $display("test control done");
    results();
  end
endmodule
